// ---- verilog/tone_port_pkg.sv ----
// Constants shared by the tone transceiver host port
`default_nettype none
package tone_port_pkg;
    // Register select values
    localparam logic SEL_DATA = 1'b0;
    localparam logic SEL_CONTROL = 1'b1;
    localparam int REG_WIDTH = 4;
    // Control A fields
    localparam int CA_TONE_OUTPUT_ENABLE = 0;
    localparam int CA_CALL_PROGRESS_SELECT = 1;
    localparam int CA_IRQ_ENABLE = 2;
    localparam int CA_SECOND_CONTROL_SELECT = 3;
    // Control B fields
    localparam int CB_BURST_ENABLE_N = 0;
    localparam int CB_RECEIVER_ENABLE_N = 1;
    localparam int CB_SINGLE_TONE = 2;
    localparam int CB_COLUMN_TONE = 3;
    // Status fields
    localparam int ST_IRQ = 0;
    localparam int ST_TX_EMPTY = 1;
    localparam int ST_RX_FULL = 2;
    localparam int ST_DELAYED_STEER = 3;
    // Reset values
    localparam logic [3:0] CONTROL_A_RESET = 4'h0;
    localparam logic [3:0] CONTROL_B_RESET = 4'h0;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] CODE_RESET = 4'h0;
    // Burst timing
    localparam int CLK_HZ = 20_000_000;
    localparam int BURST_MS = 51;
    localparam int BURST_CYCLES = BURST_MS * (CLK_HZ / 1000);
    localparam int BURST_CNT_W = 22;
endpackage : tone_port_pkg
`default_nettype wire

// ---- verilog/host_access_decoder.sv ----
// Adaptive bus-style detection and access strobes
`default_nettype none
module host_access_decoder (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_strobe_or_read_pin,
    input wire logic i_rw_or_write_n,
    input wire logic i_register_select_line,
    input wire logic [3:0] i_data,
    output logic o_sel,
    output logic o_read_active,
    output logic o_read_done,
    output logic o_write_done,
    output logic [3:0] o_write_data
);
    import tone_port_pkg::*;

    logic cs_n_q;
    logic strobe_q;
    logic wr_n_q;
    logic strobe_style;
    logic used;
    logic cs_fall;
    logic rd_now;
    logic rd_prev;
    logic wr_now;
    logic wr_prev;

    assign cs_fall = cs_n_q && !i_cs_n;
    // Strobe style: data strobe high with direction line; else separate low strobes
    assign rd_now = !i_cs_n && (strobe_style ? (i_strobe_or_read_pin && i_rw_or_write_n) : !i_strobe_or_read_pin);
    assign wr_now = !i_cs_n && (strobe_style ? (i_strobe_or_read_pin && !i_rw_or_write_n) : !i_rw_or_write_n);
    // Direction from last cycle: a host may turn it with the strobe
    assign rd_prev = strobe_style ? (strobe_q && wr_n_q) : !strobe_q;
    assign wr_prev = strobe_style ? (strobe_q && !wr_n_q) : !wr_n_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cs_n_q <= 1'b1;
            strobe_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            cs_n_q <= i_cs_n;
            strobe_q <= i_strobe_or_read_pin;
            wr_n_q <= i_rw_or_write_n;
        end
    end

    // Style and select are frozen at the chip-select edge
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            strobe_style <= 1'b0;
            o_sel <= SEL_DATA;
        end else if (cs_fall) begin
            strobe_style <= !i_strobe_or_read_pin; // [RULE1] [RULE2]
            o_sel <= i_register_select_line; // [RULE3]
        end
    end

    // Write data follows the bus while the strobe is active, so the value
    // present just before the trailing edge is what gets stored
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_write_data <= CODE_RESET;
        end else if (wr_now) begin
            o_write_data <= i_data; // [RULE3]
        end
    end

    // One access per chip-select assertion; later strobes are ignored
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            used <= 1'b0;
            o_read_done <= 1'b0;
            o_write_done <= 1'b0;
            o_read_active <= 1'b0;
        end else begin
            o_read_active <= rd_now && !used && !cs_fall;
            o_read_done <= 1'b0;
            o_write_done <= 1'b0;
            if (cs_fall || i_cs_n) begin
                used <= 1'b0;
            end else if (!used && rd_prev && !rd_now && !cs_n_q) begin
                used <= 1'b1;
                o_read_done <= 1'b1;
            end else if (!used && wr_prev && !wr_now && !cs_n_q) begin
                used <= 1'b1;
                o_write_done <= 1'b1;
            end
        end
    end
endmodule : host_access_decoder
`default_nettype wire

// ---- verilog/burst_timer.sv ----
// Equal burst and pause sequencer for the transmitter
`default_nettype none
module burst_timer #(
    parameter int P_BURST_CYCLES = tone_port_pkg::BURST_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic i_double,
    output logic o_tone_on,
    output logic o_done
);
    import tone_port_pkg::*;

    typedef enum logic [2:0] {
        IDLE = 3'b001,
        BURST = 3'b010,
        PAUSE = 3'b100
    } burst_state_t;

    burst_state_t state;
    logic [BURST_CNT_W-1:0] count;
    logic [BURST_CNT_W-1:0] limit;
    logic last;

    // Doubled interval in call progress mode
    assign limit = i_double ? BURST_CNT_W'(2 * P_BURST_CYCLES - 1) : BURST_CNT_W'(P_BURST_CYCLES - 1);
    assign last = (count >= limit);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_abort) begin
            state <= IDLE;
            count <= '0;
            o_tone_on <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (state)
                IDLE: begin
                    if (i_start) begin
                        state <= BURST;
                        count <= '0;
                        o_tone_on <= 1'b1;
                    end
                end
                BURST: begin
                    count <= count + 1'b1;
                    if (last) begin
                        state <= PAUSE;
                        count <= '0;
                        o_tone_on <= 1'b0;
                    end
                end
                PAUSE: begin
                    count <= count + 1'b1;
                    if (last) begin
                        state <= IDLE;
                        o_done <= 1'b1; // [RULE19]
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end
endmodule : burst_timer
`default_nettype wire

// ---- verilog/tone_host_port.sv ----
// Host register port of the tone signalling transceiver
// What this block does and what it expects of the host
// [RULE1] Strobe/read pin low at chip-select fall selects data-strobe timing.
// [RULE2] Strobe/read pin high at chip-select fall selects separate read/write strobes.
// [RULE3] Select and data are latched to suit the detected bus style.
// [RULE4] Status updates without any host strobe activity.
// [RULE5] Host makes a chip-select falling edge for every access.
// [RULE6] Host makes at most one access per chip-select assertion.
// [RULE7] Select 0 writes transmit, reads receive; select 1 writes control, reads status.
// [RULE8] Receive register is read-only, holds last validated code.
// [RULE9] Transmit register is write-only, its code picks the tone pair.
// [RULE10] Control A bit 3 steers the next control write to B, then back.
// [RULE11] Host software initializes both control registers after power-up.
// [RULE12] Control A bit 0 low powers transmitter down and clears transmit code.
// [RULE13] Control A bit 1 high selects call progress, low tone-pair mode.
// [RULE14] Call progress with interrupt enabled copies received tone onto pin.
// [RULE15] No tone pairs detected while call progress is selected.
// [RULE16] Interrupt pin pulls low on validated pair or burst ready.
// [RULE17] Interrupt pin is open drain: pull low or release only.
// [RULE18] Exactly five registers are reachable.
// [RULE19] Control B bit 0 low: equal burst and pause, doubled in call progress.
// [RULE20] Control B bit 1 low enables receivers, high powers them down.
// [RULE21] Control B bit 2 picks single tone, bit 3 column or row.
// [RULE22] Status: irq, transmit empty, receive full, steering; read clears low three.
// [RULE23] After reset control writes go to control A.
`default_nettype none
module tone_host_port #(
    parameter int P_BURST_CYCLES = tone_port_pkg::BURST_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_strobe_or_read_pin,
    input wire logic i_rw_or_write_n,
    input wire logic i_register_select_line,
    input wire logic [3:0] i_data,
    output logic [3:0] o_data,
    output logic o_data_oe_n,
    input wire logic i_rx_valid,
    input wire logic [3:0] i_rx_code,
    input wire logic i_rx_absent,
    input wire logic i_call_progress_wave,
    input wire logic i_interrupt_tone_pin,
    output logic o_interrupt_tone_pin,
    output logic o_interrupt_tone_pin_oe_n,
    output logic [3:0] o_tx_code,
    output logic o_tone_active,
    output logic o_tone_output_enable,
    output logic o_single_tone,
    output logic o_column_tone,
    output logic o_receiver_enable_n
);
    import tone_port_pkg::*;

    logic sel;
    logic read_active;
    logic read_done;
    logic write_done;
    logic [3:0] write_data;
    logic [3:0] transmit_code;
    logic [3:0] receive_code;
    logic [3:0] control_a;
    logic [3:0] control_b;
    logic [3:0] transceiver_state;
    logic second_pending;
    logic tx_write;
    logic ctrl_write;
    logic burst_mode;
    logic burst_done;
    logic burst_tone;
    logic rx_accept;
    logic status_read;
    logic tone_pin_unused;
    logic irq_flag;
    logic tx_empty_flag;
    logic rx_full_flag;
    logic steer_flag;

    // Pin level is not needed: the pin is only ever pulled low here
    assign tone_pin_unused = i_interrupt_tone_pin;

    host_access_decoder u_access (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_cs_n(i_cs_n),
        .i_strobe_or_read_pin(i_strobe_or_read_pin),
        .i_rw_or_write_n(i_rw_or_write_n),
        .i_register_select_line(i_register_select_line),
        .i_data(i_data),
        .o_sel(sel),
        .o_read_active(read_active),
        .o_read_done(read_done),
        .o_write_done(write_done),
        .o_write_data(write_data)
    );

    assign tx_write = write_done && (sel == SEL_DATA); // [RULE7] [RULE9]
    assign ctrl_write = write_done && (sel == SEL_CONTROL); // [RULE7]
    assign status_read = read_done && (sel == SEL_CONTROL); // [RULE22]
    assign burst_mode = !control_b[CB_BURST_ENABLE_N]; // [RULE19]
    // Receivers are blind in call progress mode or when powered down
    assign rx_accept = i_rx_valid && !control_a[CA_CALL_PROGRESS_SELECT]
        && !control_b[CB_RECEIVER_ENABLE_N]; // [RULE15] [RULE20]

    burst_timer #(
        .P_BURST_CYCLES(P_BURST_CYCLES)
    ) u_burst (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_start(tx_write && burst_mode && control_a[CA_TONE_OUTPUT_ENABLE]),
        .i_abort(!burst_mode || !control_a[CA_TONE_OUTPUT_ENABLE]),
        .i_double(control_a[CA_CALL_PROGRESS_SELECT]),
        .o_tone_on(burst_tone),
        .o_done(burst_done)
    );

    // Control registers share one address through a write pointer
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            second_pending <= 1'b0; // [RULE23]
        end else if (ctrl_write) begin
            if (second_pending) begin
                second_pending <= 1'b0; // [RULE10]
            end else begin
                second_pending <= write_data[CA_SECOND_CONTROL_SELECT]; // [RULE10]
            end
        end
    end

    // Control A takes every write unless the pointer is set
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            control_a <= CONTROL_A_RESET;
        end else if (ctrl_write && !second_pending) begin
            control_a <= write_data; // [RULE10]
        end
    end

    // Control B is reachable only through the pointer
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            control_b <= CONTROL_B_RESET;
        end else if (ctrl_write && second_pending) begin
            control_b <= write_data; // [RULE10]
        end
    end

    // Transmit code is cleared while the transmitter is powered down
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            transmit_code <= CODE_RESET;
        end else if (!control_a[CA_TONE_OUTPUT_ENABLE]) begin
            transmit_code <= CODE_RESET; // [RULE12]
        end else if (tx_write) begin
            transmit_code <= write_data; // [RULE9]
        end
    end

    // Receive code holds until the next accepted pair
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            receive_code <= CODE_RESET;
        end else if (rx_accept) begin
            receive_code <= i_rx_code; // [RULE8]
        end
    end

    // Status bits are set by receiver and timer events alone
    always_comb begin
        transceiver_state = STATUS_RESET;
        transceiver_state[ST_IRQ] = irq_flag;
        transceiver_state[ST_TX_EMPTY] = tx_empty_flag;
        transceiver_state[ST_RX_FULL] = rx_full_flag;
        transceiver_state[ST_DELAYED_STEER] = steer_flag;
    end

    // An event in the cycle of a clearing read survives
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            irq_flag <= STATUS_RESET[ST_IRQ];
        end else if (rx_accept || (burst_done && burst_mode)) begin
            irq_flag <= 1'b1; // [RULE22]
        end else if (status_read) begin
            irq_flag <= 1'b0; // [RULE22]
        end
    end

    // Transmit empty has meaning in burst mode only
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tx_empty_flag <= STATUS_RESET[ST_TX_EMPTY];
        end else if (!burst_mode) begin
            tx_empty_flag <= 1'b0; // [RULE22]
        end else if (burst_done) begin
            tx_empty_flag <= 1'b1; // [RULE4] [RULE19]
        end else if (status_read) begin
            tx_empty_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rx_full_flag <= STATUS_RESET[ST_RX_FULL];
        end else if (rx_accept) begin
            rx_full_flag <= 1'b1; // [RULE4]
        end else if (status_read) begin
            rx_full_flag <= 1'b0; // [RULE22]
        end
    end

    // Delayed steering survives a status read
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            steer_flag <= STATUS_RESET[ST_DELAYED_STEER];
        end else if (rx_accept) begin
            steer_flag <= 1'b0;
        end else if (i_rx_absent && !control_b[CB_RECEIVER_ENABLE_N]) begin
            steer_flag <= 1'b1; // [RULE4]
        end
    end

    // Read data is driven while a read strobe is active, two cycles behind the strobe at both its start and its end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_data_oe_n <= 1'b1;
        end else begin
            o_data_oe_n <= !read_active;
        end
    end

    // Data tracks the select, so it is settled before the enable drops
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_data <= CODE_RESET;
        end else begin
            o_data <= (sel == SEL_DATA) ? receive_code : transceiver_state; // [RULE7] [RULE18]
        end
    end

    // Open drain: output level is always low, only the enable moves
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_interrupt_tone_pin <= 1'b0;
        end else begin
            o_interrupt_tone_pin <= 1'b0; // [RULE17]
        end
    end

    // Released pin is pulled high outside, so a high wave releases it
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_interrupt_tone_pin_oe_n <= 1'b1;
        end else if (!control_a[CA_IRQ_ENABLE]) begin
            o_interrupt_tone_pin_oe_n <= 1'b1;
        end else if (control_a[CA_CALL_PROGRESS_SELECT]) begin
            o_interrupt_tone_pin_oe_n <= i_call_progress_wave; // [RULE14]
        end else begin
            o_interrupt_tone_pin_oe_n <= !irq_flag; // [RULE16]
        end
    end

    // Transmitter control outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_tx_code <= CODE_RESET;
            o_tone_output_enable <= 1'b0;
        end else begin
            o_tx_code <= transmit_code;
            o_tone_output_enable <= control_a[CA_TONE_OUTPUT_ENABLE]; // [RULE12]
        end
    end

    // Call progress mode sends tone in bursts only
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_tone_active <= 1'b0;
        end else if (control_a[CA_CALL_PROGRESS_SELECT]) begin
            o_tone_active <= control_a[CA_TONE_OUTPUT_ENABLE] && burst_mode && burst_tone; // [RULE13]
        end else begin
            o_tone_active <= control_a[CA_TONE_OUTPUT_ENABLE] && (burst_mode ? burst_tone : 1'b1); // [RULE19]
        end
    end

    // Tone shape follows control B
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_single_tone <= 1'b0;
            o_column_tone <= 1'b0;
        end else begin
            o_single_tone <= control_b[CB_SINGLE_TONE]; // [RULE21]
            o_column_tone <= control_b[CB_COLUMN_TONE]; // [RULE21]
        end
    end

    // Receiver power
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_receiver_enable_n <= 1'b0;
        end else begin
            o_receiver_enable_n <= control_b[CB_RECEIVER_ENABLE_N]; // [RULE20]
        end
    end
endmodule : tone_host_port
`default_nettype wire

// ---- testbench/tone_host_port_props.sv ----
// Concurrent checks on the tone host port pins
`default_nettype none
module tone_host_port_props (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_strobe_or_read_pin,
    input wire logic i_rw_or_write_n,
    input wire logic o_data_oe_n,
    input wire logic o_interrupt_tone_pin,
    input wire logic [3:0] o_tx_code,
    input wire logic o_tone_output_enable,
    input wire logic o_single_tone,
    input wire logic o_column_tone,
    input wire logic o_receiver_enable_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    a_pin_never_high: assert property (!o_interrupt_tone_pin)
        else $error("interrupt pin driven high");
    a_tx_cleared_off: assert property (!o_tone_output_enable && !$past(o_tone_output_enable) |-> o_tx_code == 4'h0)
        else $error("transmit code kept while tone output off");
    a_idle_no_drive: assert property (i_cs_n && $past(i_cs_n) && $past(i_cs_n, 2) |-> o_data_oe_n)
        else $error("data bus driven while deselected");
    a_strobe_read_drive: assert property ($fell(i_cs_n) && !i_strobe_or_read_pin
        ##1 (i_strobe_or_read_pin && i_rw_or_write_n && !i_cs_n) [*3] |-> !o_data_oe_n)
        else $error("strobe style read not driven");
    a_split_read_drive: assert property ($fell(i_cs_n) && i_strobe_or_read_pin
        ##1 (!i_strobe_or_read_pin && !i_cs_n) [*3] |-> !o_data_oe_n)
        else $error("read strobe style read not driven");
    a_strobe_write_quiet: assert property ($fell(i_cs_n) && !i_strobe_or_read_pin
        ##1 (!i_rw_or_write_n && !i_cs_n) [*2] |-> o_data_oe_n [*3])
        else $error("data bus driven during strobe style write");
    a_split_write_quiet: assert property ($fell(i_cs_n) && i_strobe_or_read_pin
        ##1 (i_strobe_or_read_pin && !i_rw_or_write_n && !i_cs_n) [*2] |-> o_data_oe_n [*3])
        else $error("data bus driven during write strobe style write");
    // Control outputs move only as the result of a host write
    a_ctrl_change_cause: assert property (!$stable({o_tone_output_enable, o_single_tone, o_column_tone,
        o_receiver_enable_n}) |-> !$past(i_cs_n, 2) || !$past(i_cs_n, 3))
        else $error("control output changed without access");
endmodule : tone_host_port_props
bind tone_host_port tone_host_port_props i_props (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_cs_n(i_cs_n),
    .i_strobe_or_read_pin(i_strobe_or_read_pin),
    .i_rw_or_write_n(i_rw_or_write_n),
    .o_data_oe_n(o_data_oe_n),
    .o_interrupt_tone_pin(o_interrupt_tone_pin),
    .o_tx_code(o_tx_code),
    .o_tone_output_enable(o_tone_output_enable),
    .o_single_tone(o_single_tone),
    .o_column_tone(o_column_tone),
    .o_receiver_enable_n(o_receiver_enable_n)
);
`default_nettype wire

// ---- testbench/host_model.sv ----
// Host microcontroller model on the adaptive bus
`default_nettype none
module host_model (
    input wire logic i_clk_sys,
    input wire logic i_data_oe_n,
    input wire logic [3:0] i_data,
    output logic o_cs_n,
    output logic o_strobe_or_read_pin,
    output logic o_rw_or_write_n,
    output logic o_register_select_line,
    output logic [3:0] o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_cs_n = 1'b1;
        o_strobe_or_read_pin = 1'b0;
        o_rw_or_write_n = 1'b1;
        o_register_select_line = 1'b0;
        o_data = 4'h0;
    end
    // One access per select assertion, always from a fresh falling edge
    task automatic access(input logic sep, input logic sel, input logic wr, input logic [3:0] wd,
                          output logic [3:0] rd, output logic ok);
        int n;
        ok = 1'b1;
        rd = 'x;
        @(posedge i_clk_sys);
        o_cs_n <= 1'b0;
        o_strobe_or_read_pin <= sep;
        o_rw_or_write_n <= 1'b1;
        o_register_select_line <= sel;
        @(posedge i_clk_sys);
        o_data <= wd;
        if (sep) begin
            if (wr) o_rw_or_write_n <= 1'b0;
            else o_strobe_or_read_pin <= 1'b0;
        end else begin
            o_strobe_or_read_pin <= 1'b1;
            o_rw_or_write_n <= !wr;
        end
        if (wr) begin
            repeat (2) @(posedge i_clk_sys);
        end else begin
            n = 0;
            do begin
                @(posedge i_clk_sys);
                #1;
                n++;
            end while (i_data_oe_n !== 1'b0 && n < 8);
            ok = (i_data_oe_n === 1'b0);
            rd = i_data;
            @(posedge i_clk_sys);
        end
        // Released lines show the inverse so stale data cannot pass
        o_strobe_or_read_pin <= sep;
        o_rw_or_write_n <= 1'b1;
        o_data <= ~wd;
        @(posedge i_clk_sys);
        o_cs_n <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
    endtask : access
endmodule : host_model
`default_nettype wire

// ---- testbench/tone_host_port_test.sv ----
// Self-checking bench for the tone host port
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tone_host_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys, i_rst, cs_n, sor, rw, rs, rx_valid, rx_absent, cp_wave;
    logic [3:0] wdata, rdata, rx_code, tx_code;
    logic oe_n, pin, pin_oe_n, tone_active, tone_en, single, column, rx_en_n;
    wire pin_level = pin_oe_n ? 1'b1 : pin;
    int n_mismatch = 0;
    int checks = 0;
    int n_tone = 0;
    host_model i_host_model (.i_clk_sys(i_clk_sys), .i_data_oe_n(oe_n), .i_data(rdata), .o_cs_n(cs_n),
        .o_strobe_or_read_pin(sor), .o_rw_or_write_n(rw), .o_register_select_line(rs), .o_data(wdata));
    tone_host_port #(.P_BURST_CYCLES(20)) i_tone_host_port (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_cs_n(cs_n), .i_strobe_or_read_pin(sor), .i_rw_or_write_n(rw), .i_register_select_line(rs),
        .i_data(wdata), .o_data(rdata), .o_data_oe_n(oe_n), .i_rx_valid(rx_valid), .i_rx_code(rx_code),
        .i_rx_absent(rx_absent), .i_call_progress_wave(cp_wave), .i_interrupt_tone_pin(pin_level),
        .o_interrupt_tone_pin(pin), .o_interrupt_tone_pin_oe_n(pin_oe_n), .o_tx_code(tx_code),
        .o_tone_active(tone_active), .o_tone_output_enable(tone_en), .o_single_tone(single),
        .o_column_tone(column), .o_receiver_enable_n(rx_en_n));
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) if (tone_active === 1'b1) n_tone <= n_tone + 1;
    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic wr(input logic sep, input logic sel, input logic [3:0] d);
        logic [3:0] r;
        logic ok;
        i_host_model.access(sep, sel, 1'b1, d, r, ok);
        #1;
    endtask : wr
    task automatic rd(input logic sep, input logic sel, input logic [3:0] ex, input string nm);
        logic [3:0] r;
        logic ok;
        i_host_model.access(sep, sel, 1'b0, 4'h0, r, ok);
        if (ok !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end else begin
            `CHK(nm, ex, r)
        end
        #1;
    endtask : rd
    task automatic pulse(input logic v, input logic a, input logic [3:0] c);
        @(posedge i_clk_sys);
        rx_valid <= v;
        rx_absent <= a;
        rx_code <= c;
        @(posedge i_clk_sys);
        rx_valid <= 1'b0;
        rx_absent <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
    endtask : pulse
    initial begin
        i_rst = 1'b1;
        rx_valid = 1'b0;
        rx_absent = 1'b0;
        rx_code = 4'h0;
        cp_wave = 1'b1;
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd(1'b0, 1'b1, 4'h0, "status");
        wr(1'b0, 1'b1, 4'h0);
        wr(1'b0, 1'b1, 4'h0);
        wr(1'b0, 1'b1, 4'h8);
        wr(1'b0, 1'b1, 4'h0);
        wr(1'b1, 1'b1, 4'h9);
        `CHK("tone_output_enable", 1'b1, tone_en)
        wr(1'b1, 1'b1, 4'hE);
        `CHK("control_b outputs", 4'hF, {single, column, rx_en_n, tone_en})
        wr(1'b1, 1'b0, 4'h5);
        `CHK("tx_code", 4'h5, tx_code)
        wr(1'b0, 1'b1, 4'h4);
        `CHK("tone_output_enable", 2'b01, {tone_en, single})
        `CHK("tx_code", 4'h0, tx_code)
        wr(1'b0, 1'b1, 4'hC);
        wr(1'b0, 1'b1, 4'h1);
        pulse(1'b1, 1'b0, 4'hA);
        rd(1'b1, 1'b0, 4'hA, "receive_code");
        `CHK("pin_oe_n", 1'b0, pin_oe_n)
        rd(1'b0, 1'b1, 4'h5, "status");
        rd(1'b1, 1'b1, 4'h0, "status");
        `CHK("pin_oe_n", 1'b1, pin_oe_n)
        pulse(1'b0, 1'b1, 4'h0);
        rd(1'b0, 1'b1, 4'h8, "status");
        wr(1'b0, 1'b1, 4'h6);
        pulse(1'b1, 1'b0, 4'h3);
        rd(1'b0, 1'b0, 4'hA, "receive_code");
        rd(1'b0, 1'b1, 4'h8, "status");
        cp_wave <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        #1;
        `CHK("pin_oe_n", 1'b0, pin_oe_n)
        cp_wave <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        #1;
        `CHK("pin_oe_n", 1'b1, pin_oe_n)
        for (int i = 0; i < 2; i++) begin
            wr(1'b0, 1'b1, {2'b11, i[0], 1'b1});
            wr(1'b0, 1'b1, 4'h0);
            n_tone = 0;
            wr(1'b1, 1'b0, 4'h7);
            // Burst plus pause, with margin for pipeline delay
            repeat (100) @(posedge i_clk_sys);
            #1;
            `CHK("burst length", 20 * (i + 1), n_tone)
            `CHK("pin_oe_n", i[0], pin_oe_n)
            rd(1'b0, 1'b1, 4'hB, "status");
        end
        end_sim();
    end
endmodule : tone_host_port_test
`default_nettype wire
